// File: pfa_core_model.sv
module pfa_core_model
    import pfa_pkg::*;
(
    input wire logic                   clk_sys,
    input wire logic                   rstn,
    input wire logic                   slow,
    input wire pfa_pkg::pfa_core_ctl_t core_ctl,
    input wire pfa_pkg::pfa_arr_req_t  arr_req,
    output logic                       inst_tick,
    output logic [13:0]                arr_rdata
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [2:0]  slot_cnt_reg;
    logic [13:0] last_reg;
    wire  [2:0]  slot_end = slow ? 3'h4 : 3'h1;
    wire  [13:0] word = arr_req.addr[13:0] ^ 14'h2A5A;

    // ==========================================
    // slot ticks, none while stalled
    always_ff @(posedge clk_sys or negedge rstn) begin
        if (!rstn) begin
            slot_cnt_reg <= 3'h0;
            inst_tick <= 1'b0;
        end else if (core_ctl.stall) begin
            inst_tick <= 1'b0;
        end else begin
            // one tick per slot, so no two-slot op lands in a nop slot
            inst_tick <= (slot_cnt_reg == slot_end);
            slot_cnt_reg <= (slot_cnt_reg == slot_end) ? 3'h0 : slot_cnt_reg + 3'h1;
        end
    end

    // ==========================================
    // array answers only in the read slot; otherwise garbage, not the old word
    always_ff @(posedge clk_sys) begin
        if (arr_req.rd) last_reg <= word;
    end
    assign arr_rdata = arr_req.rd ? word : ~last_reg;
endmodule

// File: pfa_flash_ctrl.sv
module pfa_flash_ctrl #(
    parameter int OP_CYCLES = pfa_pkg::OP_CYCLES
) (
    input  wire logic                  clk_sys,
    input  wire logic                  rstn,
    input  wire logic                  por_rstn,
    input  wire logic                  psel,
    input  wire logic                  penable,
    input  wire logic                  pwrite,
    input  wire logic [7:0]            paddr,
    input  wire logic [31:0]           pwdata,
    output logic [31:0]                prdata,
    output logic                       pready,
    output logic                       pslverr,
    input  wire logic                  inst_tick,
    output pfa_pkg::pfa_core_ctl_t     core_ctl,
    output pfa_pkg::pfa_arr_req_t      arr_req,
    input  wire logic [13:0]           arr_rdata,
    output logic [31:0][13:0]          row_data
);
    import pfa_pkg::*;

    // ==========================================================
    // state
    pfa_state_t                 state_reg;
    pfa_state_t                 state_next;
    logic [7:0]                 addr_low_reg;
    logic [6:0]                 addr_high_reg;
    logic [7:0]                 data_low_reg;
    logic [5:0]                 data_high_reg;
    logic                       rd_reg;
    logic                       wr_reg;
    logic                       write_allow_bit;
    logic                       write_fault_flag;
    logic                       erase_select;
    logic                       latch_only_select;
    logic                       config_space_select;
    logic [1:0]                 key_stage_reg;
    logic [1:0]                 key_stage_next;
    logic                       op_live_reg;
    logic [17:0]                timer_reg;
    logic [31:0]                prdata_reg;
    pfa_arr_req_t               arr_req_reg;
    logic [LATCH_WORDS-1:0][DATA_W-1:0] latch_reg;

    // ==========================================================
    // bus decode
    wire logic        setup_ph = psel & ~penable;
    wire logic        acc_ph   = psel & penable;
    wire logic        wr_acc   = acc_ph & pwrite;
    wire logic        hit_alow = (paddr == OFF_ADDR_LOW);
    wire logic        hit_ahigh = (paddr == OFF_ADDR_HIGH);
    wire logic        hit_dlow = (paddr == OFF_DATA_LOW);
    wire logic        hit_dhigh = (paddr == OFF_DATA_HIGH);
    wire logic        hit_ctl  = (paddr == OFF_CONTROL);
    wire logic        hit_key  = (paddr == OFF_UNLOCK);
    wire logic        mapped   = hit_alow | hit_ahigh | hit_dlow | hit_dhigh
                                 | hit_ctl | hit_key;
    wire logic        wr_alow  = wr_acc & hit_alow;
    wire logic        wr_ahigh = wr_acc & hit_ahigh;
    wire logic        wr_dlow  = wr_acc & hit_dlow;
    wire logic        wr_dhigh = wr_acc & hit_dhigh;
    wire logic        wr_ctl   = wr_acc & hit_ctl;
    wire logic        wr_key   = wr_acc & hit_key;

    assign pready  = 1'b1;
    assign pslverr = acc_ph & ~mapped;
    assign prdata  = prdata_reg;

    // ==========================================================
    // read-back mux
    wire logic [7:0]  ctl_view = {1'b0, config_space_select, latch_only_select,
                                  erase_select, write_fault_flag, write_allow_bit,
                                  wr_reg, rd_reg};
    wire logic [31:0] rd_mux =
        hit_alow  ? {24'h000000, addr_low_reg} :
        hit_ahigh ? {25'h0000000, addr_high_reg} :
        hit_dlow  ? {24'h000000, data_low_reg} :
        hit_dhigh ? {26'h0000000, data_high_reg} :
        hit_ctl   ? {24'h000000, ctl_view} :
        32'h00000000;  // key register never reads back

    // ==========================================================
    // sequencer decode
    wire logic [ADDR_W-1:0] word_addr = {addr_high_reg, addr_low_reg};
    wire logic [LATCH_SEL_W-1:0] latch_sel =
        addr_low_reg[LATCH_SEL_W-1:0];
    wire logic [DATA_W-1:0] data_word = {data_high_reg, data_low_reg};
    wire logic idle      = (state_reg == PFA_IDLE);
    wire logic ask_rd    = wr_ctl & pwdata[BIT_RD] & ~rd_reg & ~wr_reg & idle;
    wire logic ask_wr    = wr_ctl & pwdata[BIT_WR] & ~wr_reg & ~rd_reg & idle;
    // full key pair and write allow, else no write starts
    wire logic start_wr  = ask_wr & (key_stage_reg == 2'd2)
                           & write_allow_bit;
    wire logic start_rd  = ask_rd & ~ask_wr;
    wire logic last_nop  = (state_reg == PFA_WR_N2) & inst_tick;
    wire logic load_only = latch_only_select & ~erase_select;
    wire logic do_erase  = erase_select & write_allow_bit;
    wire logic enter_stall = last_nop & ~load_only;
    wire logic stall_done  = (state_reg == PFA_STALL) & (timer_reg == 18'h00000);
    wire logic rd_done     = (state_reg == PFA_RD_N) & inst_tick;
    wire logic fault_hw_set = op_live_reg & (state_reg != PFA_STALL);

    // ==========================================================
    // next state
    always_comb begin
        state_next = state_reg;
        case (state_reg)
            PFA_IDLE: begin
                if (start_wr) begin
                    state_next = PFA_WR_A;
                end else if (start_rd) begin
                    state_next = PFA_RD_A;
                end
            end
            PFA_RD_A: begin
                if (inst_tick) begin
                    state_next = PFA_RD_N;
                end
            end
            PFA_RD_N: begin
                if (inst_tick) begin
                    state_next = PFA_IDLE;
                end
            end
            PFA_WR_A: begin
                if (inst_tick) begin
                    state_next = PFA_WR_N1;
                end
            end
            PFA_WR_N1: begin
                if (inst_tick) begin
                    state_next = PFA_WR_N2;
                end
            end
            PFA_WR_N2: begin
                if (inst_tick) begin
                    state_next = load_only ? PFA_IDLE : PFA_STALL;
                end
            end
            PFA_STALL: begin
                if (stall_done) begin
                    state_next = PFA_IDLE;
                end
            end
            default: begin
                state_next = PFA_IDLE;
            end
        endcase
    end

    // ==========================================================
    // unlock key tracking; any other write breaks the chain
    always_comb begin
        key_stage_next = 2'd0;
        if (wr_key) begin
            if (key_stage_reg == 2'd0 && pwdata[7:0] == KEY_FIRST) begin
                key_stage_next = 2'd1;
            end else if (key_stage_reg == 2'd1 && pwdata[7:0] == KEY_SECOND) begin
                key_stage_next = 2'd2;
            end
        end else if (!wr_acc) begin
            key_stage_next = key_stage_reg;
        end
    end

    // ==========================================================
    // core slot control
    assign core_ctl.slot_nop = (state_reg == PFA_RD_N) | (state_reg == PFA_WR_N1)
                               | (state_reg == PFA_WR_N2);
    assign core_ctl.stall    = (state_reg == PFA_STALL);
    assign arr_req  = arr_req_reg;
    assign row_data = latch_reg;

    // ==========================================================
    // sequencer and key registers
    always_ff @(posedge clk_sys or negedge rstn) begin
        if (!rstn) begin
            state_reg     <= PFA_IDLE;
            key_stage_reg <= 2'd0;
        end else begin
            state_reg     <= state_next;
            key_stage_reg <= key_stage_next;
        end
    end

    // ==========================================================
    // operation timer; about 2 ms at the core clock
    always_ff @(posedge clk_sys or negedge rstn) begin
        if (!rstn) begin
            timer_reg <= 18'h00000;
        end else if (enter_stall) begin
            timer_reg <= 18'(OP_CYCLES - 1);
        end else if (timer_reg != 18'h00000) begin
            timer_reg <= timer_reg - 18'h00001;
        end
    end

    // ==========================================================
    // address and data pair
    always_ff @(posedge clk_sys or negedge rstn) begin
        if (!rstn) begin
            addr_low_reg  <= BYTE_RST;
            addr_high_reg <= ADDR_HIGH_RST;
            data_low_reg  <= BYTE_RST;
            data_high_reg <= DATA_HIGH_RST;
        end else begin
            if (wr_alow) begin
                addr_low_reg <= pwdata[7:0];
            end
            if (wr_ahigh) begin
                addr_high_reg <= pwdata[6:0];
            end
            if (rd_done) begin
                data_low_reg  <= arr_rdata[7:0];
                data_high_reg <= arr_rdata[13:8];
            end else begin
                if (wr_dlow) begin
                    data_low_reg <= pwdata[7:0];
                end
                if (wr_dhigh) begin
                    data_high_reg <= pwdata[5:0];
                end
            end
        end
    end

    // ==========================================================
    // control bits; start bits cannot be cleared by a write
    always_ff @(posedge clk_sys or negedge rstn) begin
        if (!rstn) begin
            rd_reg              <= 1'b0;
            wr_reg              <= 1'b0;
            write_allow_bit     <= 1'b0;
            erase_select        <= 1'b0;
            latch_only_select   <= 1'b0;
            config_space_select <= 1'b0;
        end else begin
            if (start_rd) begin
                rd_reg <= 1'b1;
            end else if (rd_done) begin
                rd_reg <= 1'b0;
            end
            if (start_wr) begin
                wr_reg <= 1'b1;
            end else if ((last_nop & load_only) | stall_done) begin
                wr_reg <= 1'b0;
            end
            if (wr_ctl) begin
                write_allow_bit     <= pwdata[BIT_WRITE_ALLOW_BIT];
                erase_select        <= pwdata[BIT_ERASE];
                latch_only_select   <= pwdata[BIT_LATCH_ONLY_SELECT];
                config_space_select <= pwdata[BIT_CONFIG_SPACE_SELECT];
            end
        end
    end

    // ==========================================================
    // array requests; cfg low selects program memory
    always_ff @(posedge clk_sys or negedge rstn) begin
        if (!rstn) begin
            arr_req_reg <= '0;
        end else begin
            arr_req_reg.rd    <= (state_next == PFA_RD_N);
            arr_req_reg.erase <= enter_stall & do_erase;
            arr_req_reg.prog  <= enter_stall & ~do_erase;
            arr_req_reg.cfg   <= config_space_select;
            arr_req_reg.addr  <= word_addr;
        end
    end

    // ==========================================================
    // write latches, one row wide; loaded only from the data pair
    always_ff @(posedge clk_sys or negedge rstn) begin
        if (!rstn) begin
            latch_reg <= {LATCH_WORDS{LATCH_BLANK}};
        end else if (stall_done) begin
            latch_reg <= {LATCH_WORDS{LATCH_BLANK}};
        end else if (last_nop & ~erase_select) begin
            latch_reg[latch_sel] <= data_word;
        end
    end

    // ==========================================================
    // fault tracking survives ordinary resets; power-up clears both, and a control write can also clear the flag
    // a long operation cut short leaves op_live set with the sequencer idle
    always_ff @(posedge clk_sys or negedge por_rstn) begin
        if (!por_rstn) begin
            op_live_reg      <= 1'b0;
            write_fault_flag <= 1'b0;
        end else begin
            if (enter_stall) begin
                op_live_reg <= 1'b1;
            end else if (stall_done | fault_hw_set) begin
                op_live_reg <= 1'b0;
            end
            // hardware set wins over a software write
            if (fault_hw_set) begin
                write_fault_flag <= 1'b1;
            end else if (wr_ctl) begin
                write_fault_flag <= pwdata[BIT_WRITE_FAULT_FLAG];
            end
        end
    end

    // ==========================================================
    // read data registered in the setup phase, zero wait states
    always_ff @(posedge clk_sys or negedge rstn) begin
        if (!rstn) begin
            prdata_reg <= 32'h00000000;
        end else if (setup_ph & ~pwrite) begin
            prdata_reg <= rd_mux;
        end
    end

endmodule

// File: pfa_flash_ctrl_chk.sv
module pfa_flash_ctrl_chk
    import pfa_pkg::*;
#(
    parameter int OP_CYCLES = pfa_pkg::OP_CYCLES
) (
    input wire logic                   clk_sys,
    input wire logic                   rstn,
    input wire logic                   por_rstn,
    input wire logic                   psel,
    input wire logic                   penable,
    input wire logic                   pwrite,
    input wire logic [7:0]             paddr,
    input wire logic [31:0]            pwdata,
    input wire logic [31:0]            prdata,
    input wire logic                   pready,
    input wire logic                   pslverr,
    input wire logic                   inst_tick,
    input wire pfa_pkg::pfa_core_ctl_t core_ctl,
    input wire pfa_pkg::pfa_arr_req_t  arr_req,
    input wire logic [13:0]            arr_rdata,
    input wire logic [31:0][13:0]      row_data
);
    timeunit 1ns;
    timeprecision 1ps;
    // ==========================================
    // stall length counter
    logic [31:0] stall_cnt_reg;
    logic [31:0] stall_cnt_next;
    assign stall_cnt_next = core_ctl.stall ? stall_cnt_reg + 32'h1 : 32'h0;
    always_ff @(posedge clk_sys or negedge rstn) begin
        if (!rstn) stall_cnt_reg <= 32'h0;
        else stall_cnt_reg <= stall_cnt_next;
    end

    // ==========================================
    // assertions
    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (!rstn);
    unlock_zero_a: assert property (
        psel && !penable && !pwrite && paddr == OFF_UNLOCK |=> prdata == 32'h0)
        else $error("unlock key read not zero");
    rd_nop_a: assert property (
        $rose(arr_req.rd) |-> core_ctl.slot_nop) else $error("read slot not forced");
    rd_end_a: assert property (
        arr_req.rd && inst_tick |-> ##[1:2] !arr_req.rd) else $error("read slot too long");
    nop_ahead_a: assert property (
        $rose(core_ctl.stall) |-> $past(core_ctl.slot_nop)) else $error("stall without nops");
    pulse_stall_a: assert property (
        arr_req.erase || arr_req.prog |-> core_ctl.stall ##1 !(arr_req.erase || arr_req.prog))
        else $error("array pulse bad");
    op_excl_a: assert property (
        !(arr_req.erase && arr_req.prog)) else $error("erase and program together");
    stall_len_a: assert property (
        $fell(core_ctl.stall) |-> stall_cnt_reg >= OP_CYCLES && stall_cnt_reg <= OP_CYCLES + 2)
        else $error("stall length wrong");
    blank_after_a: assert property (
        $fell(core_ctl.stall) |-> row_data == {32{LATCH_BLANK}}) else $error("latches not blank");
    cover property (arr_req.erase);
    cover property (arr_req.prog);
    cover property ($rose(arr_req.rd));
    cover property (psel && penable && pslverr);
endmodule

bind pfa_flash_ctrl pfa_flash_ctrl_chk #(.OP_CYCLES(OP_CYCLES)) chk_i (
    .clk_sys(clk_sys), .rstn(rstn), .por_rstn(por_rstn), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .prdata(prdata), .pready(pready), .pslverr(pslverr), .inst_tick(inst_tick),
    .core_ctl(core_ctl), .arr_req(arr_req), .arr_rdata(arr_rdata), .row_data(row_data));

// File: pfa_pkg.sv
package pfa_pkg;

    // ==========================================================
    // register map, byte addresses of aligned words
    localparam logic [7:0] OFF_ADDR_LOW  = 8'h00;
    localparam logic [7:0] OFF_ADDR_HIGH = 8'h04;
    localparam logic [7:0] OFF_DATA_LOW  = 8'h08;
    localparam logic [7:0] OFF_DATA_HIGH = 8'h0C;
    localparam logic [7:0] OFF_CONTROL   = 8'h10;
    localparam logic [7:0] OFF_UNLOCK    = 8'h14;

    // ==========================================================
    // control register fields
    localparam int BIT_RD     = 0;
    localparam int BIT_WR     = 1;
    localparam int BIT_WRITE_ALLOW_BIT   = 2;
    localparam int BIT_WRITE_FAULT_FLAG  = 3;
    localparam int BIT_ERASE  = 4;
    localparam int BIT_LATCH_ONLY_SELECT   = 5;
    localparam int BIT_CONFIG_SPACE_SELECT   = 6;

    // ==========================================================
    // widths, keys and reset values
    localparam int ADDR_W      = 15;
    localparam int DATA_W      = 14;
    localparam int LATCH_WORDS = 32;
    localparam int LATCH_SEL_W = 5;
    localparam logic [7:0]  KEY_FIRST  = 8'h55;
    localparam logic [7:0]  KEY_SECOND = 8'hAA;
    localparam logic [13:0] LATCH_BLANK = 14'h3FFF;
    localparam logic [6:0]  ADDR_HIGH_RST = 7'h00;
    localparam logic [7:0]  BYTE_RST   = 8'h00;
    localparam logic [5:0]  DATA_HIGH_RST = 6'h00;

    // ==========================================================
    // timing
    localparam int CLK_PERIOD_NS = 10;
    localparam int OP_TIME_NS    = 2_000_000;
    localparam int OP_CYCLES     = OP_TIME_NS / CLK_PERIOD_NS;

    // ==========================================================
    // sequencer states, gray on each forward step; the PFA_RD_N and PFA_STALL returns to PFA_IDLE change two bits
    typedef enum logic [2:0] {
        PFA_IDLE  = 3'h0,
        PFA_WR_A  = 3'h1,
        PFA_WR_N1 = 3'h3,
        PFA_WR_N2 = 3'h2,
        PFA_STALL = 3'h6,
        PFA_RD_A  = 3'h4,
        PFA_RD_N  = 3'h5
    } pfa_state_t;

    typedef struct packed {
        logic              rd;
        logic              erase;
        logic              prog;
        logic              cfg;
        logic [ADDR_W-1:0] addr;
    } pfa_arr_req_t;

    typedef struct packed {
        logic slot_nop;
        logic stall;
    } pfa_core_ctl_t;

endpackage

// File: program_flash_self_access_tb.sv
module program_flash_self_access_tb;
    timeunit 1ns;
    timeprecision 1ps;
    import pfa_pkg::*;
    localparam int OPC = 20;
    localparam logic [31:0] C_RD = 32'h1 << BIT_RD;
    localparam logic [31:0] C_WR = 32'h1 << BIT_WR;
    localparam logic [31:0] C_AL = 32'h1 << BIT_WRITE_ALLOW_BIT;
    localparam logic [31:0] C_ER = 32'h1 << BIT_ERASE;
    localparam logic [31:0] C_LO = 32'h1 << BIT_LATCH_ONLY_SELECT;
    logic clk_sys = 0, rstn = 0, por_rstn = 0, psel = 0, penable = 0, pwrite = 0;
    logic slow = 0, pready, pslverr, inst_tick, slv;
    logic [7:0]        paddr = 8'h00;
    logic [31:0]       pwdata = 32'h0, prdata, rdv;
    logic [13:0]       arr_rdata;
    logic [31:0][13:0] row_data;
    pfa_core_ctl_t     core_ctl;
    pfa_arr_req_t      arr_req;
    int failures = 0, checks_done = 0, seed = 32'hE4A7, stalls = 0, erases = 0;

    pfa_flash_ctrl #(.OP_CYCLES(OPC)) pfa_flash_ctrl_i (
        .clk_sys(clk_sys), .rstn(rstn), .por_rstn(por_rstn), .psel(psel),
        .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
        .prdata(prdata), .pready(pready), .pslverr(pslverr), .inst_tick(inst_tick),
        .core_ctl(core_ctl), .arr_req(arr_req), .arr_rdata(arr_rdata), .row_data(row_data));
    pfa_core_model pfa_core_model_i (.clk_sys(clk_sys), .rstn(rstn), .slow(slow),
        .core_ctl(core_ctl), .arr_req(arr_req), .inst_tick(inst_tick), .arr_rdata(arr_rdata));

    always #5 clk_sys = ~clk_sys;
    always @(posedge clk_sys) begin
        if (core_ctl.stall === 1'b1) stalls <= stalls + 1;
        if (arr_req.erase === 1'b1) erases <= erases + 1;
    end

    // ==========================================
    // tasks
    task automatic report_and_stop();
        $display("checks %0d failures %0d", checks_done, failures);
        if (failures == 0 && checks_done > 0) $display("Result: passed");
        else $display("Result: failed");
        $finish;
    endtask
    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        checks_done++;
        if (seen !== exp) begin
            failures++;
            $display("MISMATCH t=%0t seen %h expected %h", $time, seen, exp);
        end
    endtask
    task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
        @(posedge clk_sys);
        psel <= 1'b1;
        pwrite <= wr;
        paddr <= a;
        pwdata <= d;
        @(posedge clk_sys);
        penable <= 1'b1;
        @(posedge clk_sys);
        // no wait-state count assumed; only the watchdog ends a hang
        while (pready !== 1'b1) begin
            @(posedge clk_sys);
        end
        rdv = prdata;
        slv = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask
    task automatic ctl_bit(input int b, input logic v);
        apb(1'b0, OFF_CONTROL, 32'h0);
        check(32'(rdv[b]), 32'(v));
    endtask
    task automatic wait_done();
        int n;
        n = 0;
        do begin
            apb(1'b0, OFF_CONTROL, 32'h0);
            n++;
        end while (rdv[1:0] !== 2'b00 && n < 100);
        check(32'(rdv[1:0]), 32'h0);
    endtask
    task automatic kick(input logic [31:0] c); // unbroken sequence
        apb(1'b1, OFF_CONTROL, c);
        apb(1'b1, OFF_UNLOCK, 32'(KEY_FIRST));
        apb(1'b1, OFF_UNLOCK, 32'(KEY_SECOND));
        apb(1'b1, OFF_CONTROL, c | C_WR);
    endtask
    task automatic pulse_reset();
        rstn <= 1'b0;
        repeat (2) @(posedge clk_sys);
        rstn <= 1'b1;
    endtask
    function automatic logic [13:0] exp_word(input logic [14:0] a);
        return a[13:0] ^ 14'h2A5A;
    endfunction

    // ==========================================
    // main sequence
    initial begin
        logic [14:0] a;
        logic [13:0] d;
        int n;
        repeat (10) @(posedge clk_sys);
        rstn <= 1'b1;
        por_rstn <= 1'b1;
        apb(1'b0, OFF_CONTROL, 32'h0);
        check(rdv, 32'h0);
        apb(1'b0, OFF_UNLOCK, 32'h0);
        check(rdv, 32'h0);
        apb(1'b0, 8'h3C, 32'h0);
        check(32'(slv), 32'h1);
        apb(1'b1, OFF_CONTROL, 32'h1 << BIT_CONFIG_SPACE_SELECT);
        ctl_bit(BIT_CONFIG_SPACE_SELECT, 1'b1);
        check(32'(arr_req.cfg), 32'h1);
        for (int i = 0; i < 6; i++) begin
            slow <= i[0];
            a = 15'($random(seed));
            apb(1'b1, OFF_ADDR_LOW, 32'(a[7:0]));
            apb(1'b1, OFF_ADDR_HIGH, 32'(a[14:8]));
            apb(1'b1, OFF_CONTROL, 32'h0);
            apb(1'b1, OFF_CONTROL, C_RD);
            if (i[0]) begin
                apb(1'b1, OFF_CONTROL, 32'h0);
                ctl_bit(BIT_RD, 1'b1);
            end
            wait_done();
            check(32'(arr_req.cfg), 32'h0);
            apb(1'b0, OFF_DATA_LOW, 32'h0);
            check(rdv, 32'(exp_word(a) & 14'h00FF));
            apb(1'b0, OFF_DATA_HIGH, 32'h0);
            check(rdv, 32'(exp_word(a) >> 8));
        end
        apb(1'b1, OFF_DATA_LOW, 32'h5A);
        apb(1'b0, OFF_DATA_LOW, 32'h0);
        check(rdv, 32'h5A);
        // refused starts: no allow, broken chain, wrong key order
        apb(1'b1, OFF_CONTROL, C_WR);
        ctl_bit(BIT_WR, 1'b0);
        apb(1'b1, OFF_UNLOCK, 32'(KEY_FIRST));
        apb(1'b1, OFF_DATA_LOW, 32'h0);
        apb(1'b1, OFF_CONTROL, C_AL | C_WR);
        ctl_bit(BIT_WR, 1'b0);
        apb(1'b1, OFF_UNLOCK, 32'(KEY_SECOND));
        apb(1'b1, OFF_UNLOCK, 32'(KEY_FIRST));
        apb(1'b1, OFF_CONTROL, C_AL | C_WR);
        ctl_bit(BIT_WR, 1'b0);
        // latch loads into a fresh row, nothing to save first
        n = stalls;
        for (int i = 0; i < 4; i++) begin
            a = 15'($random(seed));
            d = 14'($random(seed));
            apb(1'b1, OFF_ADDR_LOW, 32'(a[7:0]));
            apb(1'b1, OFF_DATA_LOW, 32'(d[7:0]));
            apb(1'b1, OFF_DATA_HIGH, 32'(d[13:8]));
            kick(C_AL | C_LO);
            wait_done();
            check(32'(row_data[a[4:0]]), 32'(d));
        end
        check(32'(stalls - n), 32'h0);
        n = stalls;
        kick(C_AL);
        wait_done();
        check(32'(stalls - n), 32'(OPC));
        check(32'(row_data[a[4:0]]), 32'(LATCH_BLANK));
        check(32'(erases), 32'h0);
        n = stalls;
        kick(C_AL | C_ER | C_LO);
        wait_done();
        check(32'(stalls - n), 32'(OPC));
        check(32'(erases), 32'h1);
        // reset in mid-operation and in mid-unlock
        kick(C_AL);
        n = 0;
        while (core_ctl.stall !== 1'b1 && n < 100) begin
            n++;
            @(posedge clk_sys);
        end
        pulse_reset();
        ctl_bit(BIT_WRITE_FAULT_FLAG, 1'b1);
        apb(1'b1, OFF_UNLOCK, 32'(KEY_FIRST));
        apb(1'b1, OFF_UNLOCK, 32'(KEY_SECOND));
        pulse_reset();
        apb(1'b1, OFF_CONTROL, C_AL | C_WR);
        ctl_bit(BIT_WR, 1'b0);
        report_and_stop();
    end

    initial begin
        #400_000;
        failures++;
        report_and_stop();
    end
endmodule
